// ---- verilog/sso_pkg.sv ----
// sso_pkg: constants for the serial status output port.
// assumes: one 10 MHz clock domain; serial pins are sampled before use.
//
// Overview of operation
// - serial-out is high impedance unless chip select is low.
// - each frame shifts a 64-bit word, most significant bit first.
// - view bit 0 gives status, 1 gives echo; bit 59 shows the view.
// - bits 62..60 hold a fixed silicon revision code.
// - bits 57..48 carry the reference-cell amplifier sample.
// - bits 47..45 carry the 3-bit measurement counter.
// - bits 44..42 flag sensor shorts to battery, one bit per site.
// - bits 41..32 carry the control-voltage sample.
// - bit 31 always 1, bit 30 always 0.
// - fault code bit 29 clear means no fault; 10 means length or confirm error.
// - an illegal command sets both fault code bits.
// - bits 25..16 carry the impedance sample before the switch.
// - bits 9..0 carry the impedance sample during the switch.
// - bit 15 flags a sense pin short to ground.
// - bit 14 flags pump current source clamp active.
// - bit 13 flags heater open circuit.
// - heater open and heater ground-short flags latch independently.
// - bit 12 flags heater short to battery.
// - bit 11 flags heater short to ground.
// - bit 10 flags reference pin short to ground.
// - echo view returns the last accepted input frame bit for bit; refused frames leave it unchanged.
// - fault-clear input bit 47 clears latched faults at chip select rise.
package sso_pkg;
  localparam int WORD_W = 64;
  localparam int CNT_W = 7;
  localparam logic [6:0] BIT_LAST = 7'h3f;
  localparam logic [6:0] BIT_FULL = 7'h40;
  localparam logic [2:0] REV_CODE = 3'h5; // arbitrary value
  localparam int POS_VIEW = 59;
  localparam int POS_CLEAR = 47;
  localparam int POS_CONF1 = 15;
  localparam int POS_CONF0 = 14;
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_LEN = 2'h2;
  localparam logic [1:0] FAULT_ILLEGAL = 2'h3;
  localparam logic [1:0] CONFIRM_BITS = 2'h2;
  localparam logic [63:0] RESET_FRAME = 64'h0;
endpackage : sso_pkg

// ---- verilog/sso_sync.sv ----
// sso_sync: two-flop synchroniser for a group of pin inputs.
// assumes: inputs are asynchronous to clk_in.
module sso_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= INIT;
      s2_q <= INIT;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end
  assign q_out = s2_q;
endmodule : sso_sync

// ---- verilog/sso_top.sv ----
// sso_top: serial output side of the sensor interface port.
// assumes: host is the serial master (mode: data out on falling link clock
// edge, sampled by host at the end of the high phase); analog results arrive as levels on mclk_in.
module sso_top
  import sso_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // serial pins
  input wire logic chip_select_low_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_n_out,
  // measurement and fault sources
  input wire logic [9:0] ref_cell_amp_sample_in,
  input wire logic [2:0] meas_count_in,
  input wire logic [2:0] sensor_batt_short_flags_in,
  input wire logic [9:0] control_volt_sample_in,
  input wire logic [9:0] impedance_sample_before_in,
  input wire logic [9:0] impedance_sample_during_in,
  input wire logic sense_pin_gnd_short_in,
  input wire logic clamp_active_in,
  input wire logic heater_open_flag_in,
  input wire logic heater_batt_short_in,
  input wire logic heater_gnd_short_in,
  input wire logic ref_pin_gnd_short_in,
  input wire logic illegal_cmd_in,
  // received frame
  output logic [63:0] rx_frame_out,
  output logic rx_valid_out
);

  // ---------------------------------------------------------------
  // reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic rst_s1_q;
  logic rst_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end

  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  sso_sync #(.W(3), .INIT(3'h4)) u_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_q),
    .d_in({chip_select_low_in, sclk_in, sdi_in}),
    .q_out({cs_s, sclk_s, sdi_s})
  );

  // ---------------------------------------------------------------
  // edge detect on synchronised pins
  // ---------------------------------------------------------------
  logic cs_prev_q;
  logic sclk_prev_q;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  always_ff @(posedge mclk_in or negedge rst_q) begin
    if (!rst_q) begin
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      sclk_prev_q <= sclk_s;
    end
  end
  assign cs_fall = cs_prev_q && !cs_s;
  assign cs_rise = !cs_prev_q && cs_s;
  assign sclk_rise = !cs_s && !sclk_prev_q && sclk_s;
  assign sclk_fall = !cs_s && sclk_prev_q && !sclk_s;

  // ---------------------------------------------------------------
  // latched fault flags and serial fault code
  // ---------------------------------------------------------------
  logic [2:0] sensor_batt_short_flags_q, sensor_batt_short_flags_d;
  logic [5:0] hfl_q, hfl_d;
  logic [1:0] sfault_q, sfault_d;
  logic view_q, view_d;
  logic [63:0] rx_sh_q, rx_sh_d;
  logic [6:0] rx_cnt_q, rx_cnt_d;
  logic [63:0] echo_q, echo_d;
  logic rx_valid_q, rx_valid_d;
  logic frame_end_ok;
  logic frame_clear;

  // a frame counts only if exactly 64 bits arrived and confirm bits match
  assign frame_end_ok = cs_rise && (rx_cnt_q == BIT_FULL)
    && (rx_sh_q[POS_CONF1:POS_CONF0] == CONFIRM_BITS);
  assign frame_clear = frame_end_ok && rx_sh_q[POS_CLEAR];

  always_comb begin
    sensor_batt_short_flags_d = sensor_batt_short_flags_q;
    hfl_d = hfl_q;
    sfault_d = sfault_q;
    view_d = view_q;
    echo_d = echo_q;
    rx_valid_d = 1'b0;
    rx_sh_d = rx_sh_q;
    rx_cnt_d = rx_cnt_q;
    if (cs_fall) begin
      rx_cnt_d = '0;
    end else if (sclk_rise && rx_cnt_q < BIT_FULL) begin
      rx_sh_d = {rx_sh_q[62:0], sdi_s};
      rx_cnt_d = rx_cnt_q + 7'h1;
    end else if (sclk_rise) begin
      rx_cnt_d = BIT_FULL + 7'h1; // marks an overlong frame
    end
    // clear acts once chip select returns high; live causes re-set at once
    if (frame_clear) begin
      sensor_batt_short_flags_d = '0;
      hfl_d = '0;
      sfault_d = FAULT_NONE;
    end
    if (cs_rise) begin
      if (rx_cnt_q != BIT_FULL || rx_sh_q[POS_CONF1:POS_CONF0] != CONFIRM_BITS) begin
        sfault_d = FAULT_LEN;
      end else begin
        echo_d = rx_sh_q;
        view_d = rx_sh_q[POS_VIEW];
        rx_valid_d = 1'b1;
      end
    end
    // set wins over clear for every latched flag
    if (illegal_cmd_in) begin
      sfault_d = FAULT_ILLEGAL;
    end
    sensor_batt_short_flags_d = sensor_batt_short_flags_d | sensor_batt_short_flags_in;
    // each heater flag latches on its own cause only
    hfl_d = hfl_d | {sense_pin_gnd_short_in, clamp_active_in, heater_open_flag_in,
      heater_batt_short_in, heater_gnd_short_in, ref_pin_gnd_short_in};
  end

  always_ff @(posedge mclk_in or negedge rst_q) begin
    if (!rst_q) begin
      sensor_batt_short_flags_q <= '0;
      hfl_q <= '0;
      sfault_q <= FAULT_NONE;
      view_q <= 1'b0;
      echo_q <= RESET_FRAME;
      rx_valid_q <= 1'b0;
      rx_sh_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      sensor_batt_short_flags_q <= sensor_batt_short_flags_d;
      hfl_q <= hfl_d;
      sfault_q <= sfault_d;
      view_q <= view_d;
      echo_q <= echo_d;
      rx_valid_q <= rx_valid_d;
      rx_sh_q <= rx_sh_d;
      rx_cnt_q <= rx_cnt_d;
    end
  end
  assign rx_frame_out = echo_q;
  assign rx_valid_out = rx_valid_q;

  // ---------------------------------------------------------------
  // status word assembly
  // ---------------------------------------------------------------
  logic [63:0] status_word;
  logic [63:0] load_word;
  always_comb begin
    status_word = '0;
    status_word[62:60] = REV_CODE;
    status_word[POS_VIEW] = view_q;
    status_word[57:48] = ref_cell_amp_sample_in;
    status_word[47:45] = meas_count_in;
    status_word[44:42] = sensor_batt_short_flags_q;
    status_word[41:32] = control_volt_sample_in;
    status_word[31:30] = CONFIRM_BITS;
    status_word[29:28] = sfault_q;
    status_word[25:16] = impedance_sample_before_in;
    status_word[15] = hfl_q[5];
    status_word[14] = hfl_q[4];
    status_word[13] = hfl_q[3];
    status_word[12] = hfl_q[2];
    status_word[11] = hfl_q[1];
    status_word[10] = hfl_q[0];
    status_word[9:0] = impedance_sample_during_in;
    load_word = view_q ? echo_q : status_word;
  end

  // ---------------------------------------------------------------
  // output shifter
  // ---------------------------------------------------------------
  logic [63:0] tx_sh_q, tx_sh_d;
  logic sdo_q, sdo_d;
  logic oe_n_q, oe_n_d;
  always_comb begin
    tx_sh_d = tx_sh_q;
    sdo_d = sdo_q;
    oe_n_d = cs_s;
    if (cs_fall) begin
      tx_sh_d = {load_word[62:0], 1'b0};
      sdo_d = load_word[63];
    end else if (sclk_fall) begin
      sdo_d = tx_sh_q[63];
      tx_sh_d = {tx_sh_q[62:0], 1'b0};
    end
  end
  always_ff @(posedge mclk_in or negedge rst_q) begin
    if (!rst_q) begin
      tx_sh_q <= '0;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      tx_sh_q <= tx_sh_d;
      sdo_q <= sdo_d;
      oe_n_q <= oe_n_d;
    end
  end
  assign sdo_out = sdo_q;
  assign sdo_oe_n_out = oe_n_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_hiz_when_idle;
    @(posedge mclk_in) disable iff (!rst_q) cs_s |=> sdo_oe_n_out;
  endproperty
  a_hiz_when_idle: assert property (p_hiz_when_idle) else $error("sdo driven while idle");
  property p_msb_first;
    @(posedge mclk_in) disable iff (!rst_q) cs_fall |=> sdo_out == $past(load_word[63]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb");
  property p_view_latched;
    @(posedge mclk_in) disable iff (!rst_q) frame_end_ok |=> view_q == $past(rx_sh_q[59]);
  endproperty
  a_view_latched: assert property (p_view_latched) else $error("view not latched");
  property p_confirm;
    @(posedge mclk_in) disable iff (!rst_q)
      (cs_fall && !view_q) |=> tx_sh_q[32:31] == CONFIRM_BITS;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm bits wrong");
  property p_len_err;
    @(posedge mclk_in) disable iff (!rst_q)
      (cs_rise && rx_cnt_q != BIT_FULL && !illegal_cmd_in) |=> sfault_q == 2'h2;
  endproperty
  a_len_err: assert property (p_len_err) else $error("length fault missed");
  property p_illegal;
    @(posedge mclk_in) disable iff (!rst_q) illegal_cmd_in |=> sfault_q == 2'h3;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal fault missed");
  sequence s_open_seen;
    heater_open_flag_in && !frame_clear;
  endsequence
  sequence s_gnd_seen;
    heater_gnd_short_in && !frame_clear;
  endsequence
  property p_heater_indep;
    @(posedge mclk_in) disable iff (!rst_q)
      s_open_seen ##1 s_gnd_seen |=> hfl_q[3] && hfl_q[1];
  endproperty
  a_heater_indep: assert property (p_heater_indep) else $error("heater flags lost");
  property p_clear;
    @(posedge mclk_in) disable iff (!rst_q)
      (frame_clear && !heater_batt_short_in) |=> !hfl_q[2];
  endproperty
  a_clear: assert property (p_clear) else $error("fault not cleared");
  property p_unused_zero;
    @(posedge mclk_in) disable iff (!rst_q)
      status_word[63] == 1'b0 && status_word[58] == 1'b0 && status_word[27:26] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");
  property p_stable_shift;
    @(posedge mclk_in) disable iff (!rst_q) (!cs_fall && !sclk_fall) |=> $stable(tx_sh_q);
  endproperty
  a_stable_shift: assert property (p_stable_shift) else $error("word moved");
  property p_capture_word;
    @(posedge mclk_in) disable iff (!rst_q)
      cs_fall |=> tx_sh_q == {$past(load_word[62:0]), 1'b0};
  endproperty
  a_capture_word: assert property (p_capture_word) else $error("word not captured");
  property p_next_bit;
    @(posedge mclk_in) disable iff (!rst_q)
      (sclk_fall && !cs_fall) |=> sdo_out == $past(tx_sh_q[63]);
  endproperty
  a_next_bit: assert property (p_next_bit) else $error("next bit wrong");
  property p_drive_when_selected;
    @(posedge mclk_in) disable iff (!rst_q) !cs_s |=> !sdo_oe_n_out;
  endproperty
  a_drive_when_selected: assert property (p_drive_when_selected) else $error("sdo not driven");
  property p_echo_taken;
    @(posedge mclk_in) disable iff (!rst_q)
      frame_end_ok |=> rx_valid_q && echo_q == $past(rx_sh_q);
  endproperty
  a_echo_taken: assert property (p_echo_taken) else $error("echo not taken");
  // a refused frame must leave the echo alone and raise the fault code
  property p_bad_frame;
    @(posedge mclk_in) disable iff (!rst_q)
      (cs_rise && !frame_end_ok) |=> !rx_valid_q && $stable(echo_q) && sfault_q[1];
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad frame accepted");
  // without a clear frame no latched flag may drop
  property p_flags_sticky;
    @(posedge mclk_in) disable iff (!rst_q)
      !frame_clear |=> (($past(hfl_q) & ~hfl_q) == 6'h0)
      && (($past(sensor_batt_short_flags_q) & ~sensor_batt_short_flags_q) == 3'h0);
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("latched flag lost");

endmodule : sso_top

// ---- verif/sso_host_model.sv ----
// sso_host_model: behavioural serial master that faces the status output port.
// assumes: clk_in is the 10 MHz system clock; the link clock runs at 800 ns.
module sso_host_model (
  // system clock
  input wire logic clk_in,
  // serial pins
  input wire logic sdo_in,
  input wire logic sdo_oe_n_in,
  output logic cs_low_out,
  output logic sclk_out,
  output logic sdi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_low_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // ----------------------------------------
  // one frame of n bits
  // ----------------------------------------
  // sdo is sampled at the end of the high phase, well after it has settled
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx,
                      output int oe_bad);
    int k;
    rx = 64'h0;
    oe_bad = 0;
    @(negedge clk_in);
    cs_low_out = 1'b0;
    repeat (6) @(negedge clk_in);
    for (k = 0; k < n; k++) begin
      sdi_out = tx[63-k];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      rx = {rx[62:0], sdo_in};
      if (sdo_oe_n_in !== 1'b0) oe_bad++;
      sclk_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    cs_low_out = 1'b1;
    // released data line no longer shows the last bit
    sdi_out = ~sdi_out;
    repeat (8) @(negedge clk_in);
  endtask : xfer
endmodule : sso_host_model

// ---- verif/sso_top_tb.sv ----
// sso_top_tb: self-checking bench for the serial status output port.
// assumes: the host model owns the serial pins; other inputs change on falling mclk.
module sso_top_tb
  import sso_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic illegal = 1'b0;
  logic cs_low, sclk, sdi, sdo, oe_n, rxv;
  logic [9:0] ra = 10'h2a5, cv = 10'h15a, ib = 10'h3c3, id = 10'h0f1;
  logic [2:0] cnt = 3'h6, sb = 3'h5;
  logic [5:0] fl = 6'h00;
  logic [63:0] rxf, rx, ea;
  int fails = 0, checks_done = 0, ob;
  int nv = 0;
  always #50 mclk = ~mclk;
  sso_top uut (.mclk_in(mclk), .rst_n_in(rst_n), .chip_select_low_in(cs_low),
    .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(oe_n),
    .ref_cell_amp_sample_in(ra), .meas_count_in(cnt), .sensor_batt_short_flags_in(sb),
    .control_volt_sample_in(cv), .impedance_sample_before_in(ib),
    .impedance_sample_during_in(id), .sense_pin_gnd_short_in(fl[5]),
    .clamp_active_in(fl[4]), .heater_open_flag_in(fl[3]), .heater_batt_short_in(fl[2]),
    .heater_gnd_short_in(fl[1]), .ref_pin_gnd_short_in(fl[0]), .illegal_cmd_in(illegal),
    .rx_frame_out(rxf), .rx_valid_out(rxv));
  sso_host_model host (.clk_in(mclk), .sdo_in(sdo), .sdo_oe_n_in(oe_n),
    .cs_low_out(cs_low), .sclk_out(sclk), .sdi_out(sdi));
  // good-frame pulses, counted away from the edge that launches them
  always @(negedge mclk) if (rxv === 1'b1) nv++;
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  function automatic logic [63:0] cmd(input logic view, input logic clr);
    return {4'h0, view, 11'h0, clr, 31'h0, 2'b10, 14'h0};
  endfunction : cmd
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic frame(input logic [63:0] tx, input int n);
    host.xfer(tx, n, rx, ob);
    chk(64'(ob), 64'h0);
  endtask : frame
  task automatic close_out();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // a mid-frame change of a sample must not reach the word already captured
  task automatic t_status();
    chk(64'(oe_n), 64'h1);
    ea = {1'b0, REV_CODE, 2'b00, ra, cnt, sb, cv, 2'b10, 4'h0, ib, 6'h15, id};
    fl = 6'h15;
    repeat (5) @(negedge mclk);
    fl = 6'h00;
    fork
      frame(cmd(1'b0, 1'b0), 64);
      begin
        repeat (40) @(negedge mclk);
        ra = 10'h111;
      end
    join
    chk(rx, ea);
  endtask : t_status
  task automatic t_echo();
    frame(64'h0a5a_3c3c_1234_8e01, 64);
    chk(rxf, 64'h0a5a_3c3c_1234_8e01);
    frame(64'h08ff_00ff_a5a5_b00f, 64);
    chk(rx, 64'h0a5a_3c3c_1234_8e01);
    frame(cmd(1'b0, 1'b0), 64);
    chk(rx, 64'h08ff_00ff_a5a5_b00f);
    frame(cmd(1'b0, 1'b0), 64);
    chk(64'(rx[62:59]), 64'({REV_CODE, 1'b0}));
  endtask : t_echo
  task automatic t_clear();
    frame(cmd(1'b0, 1'b1), 64);
    frame(cmd(1'b0, 1'b0), 64);
    chk(64'(rx[15:10]), 64'h0);
    fl = 6'h08;
    repeat (5) @(negedge mclk);
    fl = 6'h02;
    repeat (5) @(negedge mclk);
    fl = 6'h00;
    frame(cmd(1'b0, 1'b0), 64);
    chk(64'(rx[15:10]), 64'h0a);
  endtask : t_clear
  task automatic t_faults();
    frame(cmd(1'b0, 1'b0) | 64'h1, 64);
    frame(cmd(1'b0, 1'b0), 63);
    chk(rxf, cmd(1'b0, 1'b0) | 64'h1);
    frame(cmd(1'b0, 1'b0), 64);
    chk(64'(rx[29:28]), 64'h2);
    frame(cmd(1'b0, 1'b1) | 64'h3, 64);
    frame(cmd(1'b0, 1'b0) | 64'h4000, 64);
    chk(64'(rx[29:28]), 64'h0);
    chk(rxf, cmd(1'b0, 1'b1) | 64'h3);
    frame(cmd(1'b0, 1'b0), 64);
    chk(64'(rx[29:28]), 64'h2);
    illegal = 1'b1;
    repeat (3) @(negedge mclk);
    illegal = 1'b0;
    frame(cmd(1'b0, 1'b0), 64);
    chk(64'(rx[29:28]), 64'h3);
    chk(64'(nv), 64'hd);
  endtask : t_faults
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    t_status();
    t_echo();
    t_clear();
    t_faults();
    close_out();
  end
  // about 15 frames of 53 us each; three times that before giving up
  initial begin
    #2_400_000;
    fails++;
    close_out();
  end
endmodule : sso_top_tb
